// File: hdl/stm_timer.v
// Standard timer with compare match, timer/counter and PWM modes, AXI4-Lite registers
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`default_nettype none
`include "stm_consts.vh"

// Operation
// - Rising on bit restores initial pin level
// - Level bit: initial level or active level
// - Single pulse starts at level-bit level
// - Polarity bit inverts pin, ignored timer mode
// - Swap bit exchanges period and duty roles
// - Clear on A match, else P/overflow
// - Overflow clear only when period zero
// - Clear select ignored in PWM modes
// - Counter readable as low/high bytes
// - Compare A held as read/write bytes
// - Mode field selects compare, PWM, timer
// - Clear select low raises both flags
// - Clear select high raises A only
// - Zero compare A overflows without A flag
// - Pin changes only on A match
// - A match sets, clears or toggles pin
// - Timer mode like compare, pin unused
// - PWM: one compare sets period, other duty
// - PWM raises both match flags, single pulse raises A only
// - PWM pin function passes or forces level
// - Period value versus counter top three bits
// - On rise clears counter, fall holds it
// - PWM function encoding four choices
// - Duty at or above period gives full
module stm_timer #(
  parameter CW = 10,
  parameter PW = 3
) (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        clk_en,
  input  wire        tick,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         pin_out_r,
  output reg         pin_oe_r,
  output reg         match_a_flag_r,
  output reg         match_p_flag_r
);

  localparam [CW-1:0] CNT_MAX = {CW{1'b1}};
  localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////
  // Registers and state
  reg  [7:0]    ctrl0_r;
  reg  [7:0]    ctrl1_r;
  reg  [CW-1:0] cmpa_r;
  reg  [CW-1:0] cnt_r;
  reg           on_d_r;
  reg           level_r;
  reg  [7:0]    aw_addr_r;
  reg           aw_have_r;
  reg  [31:0]   w_data_r;
  reg  [3:0]    w_strb_r;
  reg           w_have_r;

  wire          on_bit   = ctrl0_r[`STM_C0_ON];
  wire [PW-1:0] period_v = ctrl0_r[`STM_C0_RP_HI -: PW];
  wire [1:0]    mode     = {ctrl1_r[`STM_C1_MODE_HI], ctrl1_r[`STM_C1_MODE_LO]};
  wire [1:0]    func     = {ctrl1_r[`STM_C1_FUNC_HI], ctrl1_r[`STM_C1_FUNC_LO]};
  wire          oc       = ctrl1_r[`STM_C1_OC];
  wire          pol      = ctrl1_r[`STM_C1_POL];
  wire          dpx      = ctrl1_r[`STM_C1_DPX];
  wire          cclr     = ctrl1_r[`STM_C1_CCLR];

  ////////////////////////////////////////////////////////////////
  // Comparators
  // All compares look at the counter before it advances, so a
  // match is seen on the tick that leaves the matching value and
  // the clear, flag and level change land on that same edge, the pin one clock later.
  wire          is_pwm   = (mode == `STM_MODE_PWM);
  wire          is_pulse = is_pwm && (func == `STM_PF_PULSE);
  wire          is_cmp   = (mode == `STM_MODE_CMP) || (mode == `STM_MODE_TMR);
  wire          on_rise  = on_bit && !on_d_r;
  wire          running  = on_bit && on_d_r && tick;
  // Period compare against top bits, zero means full range
  wire          p_hit    = (period_v != {PW{1'b0}}) &&
                           (cnt_r[CW-1 -: PW] == period_v) &&
                           (cnt_r[CW-PW-1:0] == {(CW-PW){1'b0}});
  wire          ovf      = (cnt_r == CNT_MAX);
  wire          a_hit    = (cmpa_r != {CW{1'b0}}) && (cnt_r == cmpa_r);
  // Period boundary value for PWM, zero period is full count
  wire [CW:0]   p_full   = (period_v == {PW{1'b0}}) ? {1'b1, {CW{1'b0}}} :
                           {1'b0, period_v, {(CW-PW){1'b0}}};
  wire [CW:0]   per_val  = dpx ? {1'b0, cmpa_r} : p_full;
  wire [CW:0]   duty_val = dpx ? p_full : {1'b0, cmpa_r};
  wire          pwm_end  = dpx ? a_hit : (p_hit || (period_v == {PW{1'b0}} && ovf));
  wire          duty_on  = (duty_val >= per_val) ||
                           ({1'b0, cnt_r} < duty_val);

  // Counter clear choice
  // Single pulse never clears here: only a rising on bit restarts
  // the count, so the pulse width is set by compare A alone.
  // The clear select bit only matters outside the PWM modes, capture mode included.
  reg           clr_now;
  reg           set_a;
  reg           set_p;
  always @* begin
    clr_now = 1'b0;
    set_a   = a_hit;
    set_p   = p_hit;
    if (is_pulse) begin
      clr_now = 1'b0;
      set_p   = 1'b0;
    end else if (is_pwm) begin
      clr_now = pwm_end;
    end else if (cclr) begin
      clr_now = a_hit;
      set_p   = 1'b0;
    end else begin
      clr_now = p_hit || (period_v == {PW{1'b0}} && ovf);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Signals built further down; the counter process uses all but wr_ok
  reg           pin_nxt;
  wire          flag_clr_a;
  wire          flag_clr_p;
  reg           wr_ok;

  ////////////////////////////////////////////////////////////////
  // Counter, flags and output level
  // The on bit is delayed one cycle so that the edge after a rise
  // restarts from zero; a tick in that cycle is not counted, which
  // keeps the first period of every run the full length.
  // Flags are updated every enabled cycle, even while stopped, so a
  // software clear is never lost when the counter is off.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r          <= `STM_RST_CNT;
      on_d_r         <= 1'b0;
      level_r        <= 1'b0;
      match_a_flag_r <= 1'b0;
      match_p_flag_r <= 1'b0;
      pin_out_r      <= 1'b0;
      pin_oe_r       <= 1'b0;
    end else if (clk_en) begin
      on_d_r <= on_bit;
      if (on_rise) begin
        cnt_r   <= `STM_RST_CNT;
        level_r <= oc;
      end else if (running) begin
        cnt_r <= clr_now ? `STM_RST_CNT : cnt_r + CNT_ONE;
        if (is_cmp && set_a) begin
          case (func)
            `STM_CF_LOW:    level_r <= 1'b0;
            `STM_CF_HIGH:   level_r <= 1'b1;
            `STM_CF_TOGGLE: level_r <= ~level_r;
            default:        level_r <= level_r;
          endcase
        end
        if (is_pulse && a_hit) begin
          level_r <= ~oc;
        end
      end
      // Flags: hardware set wins over software clear
      if (running && set_a) begin
        match_a_flag_r <= 1'b1;
      end else if (flag_clr_a) begin
        match_a_flag_r <= 1'b0;
      end
      if (running && set_p) begin
        match_p_flag_r <= 1'b1;
      end else if (flag_clr_p) begin
        match_p_flag_r <= 1'b0;
      end
      pin_out_r <= pin_nxt ^ (pol && mode != `STM_MODE_TMR);
      pin_oe_r  <= (mode != `STM_MODE_TMR) && (mode != `STM_MODE_CAP);
    end
  end

  // Pin level before polarity stage
  // Forced levels follow the active level bit at once, so the pin
  // is defined even while the counter is off.
  // PWM gating uses the live on bit to park the pin inactive.
  always @* begin
    pin_nxt = level_r;
    if (is_pwm && !is_pulse) begin
      case (func)
        `STM_PF_INACT: pin_nxt = ~oc;
        `STM_PF_ACT:   pin_nxt = oc;
        default:       pin_nxt = (on_bit && duty_on) ? oc : ~oc;
      endcase
    end else if (is_pulse) begin
      pin_nxt = (on_bit && on_d_r) ? level_r : ~oc;
    end else if (mode == `STM_MODE_TMR) begin
      pin_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite write side
  // Address and data are latched separately and applied together;
  // a new write is held off until the previous response is gone.
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire do_wr   = aw_have_r && w_have_r && !s_axi_bvalid;
  wire lane0   = w_strb_r[0];
  assign flag_clr_a = do_wr && lane0 && (aw_addr_r == `STM_ADDR_FLAGS) && w_data_r[`STM_FLAG_A];
  assign flag_clr_p = do_wr && lane0 && (aw_addr_r == `STM_ADDR_FLAGS) && w_data_r[`STM_FLAG_P];

  // Address decode of the latched write address
  always @* begin
    wr_ok = 1'b1;
    if (aw_addr_r == `STM_ADDR_CTRL0) begin
      wr_ok = 1'b1;
    end else if (aw_addr_r == `STM_ADDR_CTRL1) begin
      wr_ok = 1'b1;
    end else if (aw_addr_r == `STM_ADDR_CNT_LO) begin
      wr_ok = 1'b1; // Accepted, value ignored
    end else if (aw_addr_r == `STM_ADDR_CNT_HI) begin
      wr_ok = 1'b1; // Accepted, value ignored
    end else if (aw_addr_r == `STM_ADDR_CMPA_LO) begin
      wr_ok = 1'b1;
    end else if (aw_addr_r == `STM_ADDR_CMPA_HI) begin
      wr_ok = 1'b1;
    end else if (aw_addr_r == `STM_ADDR_FLAGS) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `STM_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= `STM_RST_BYTE;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      ctrl0_r       <= `STM_RST_BYTE;
      ctrl1_r       <= `STM_RST_BYTE;
      cmpa_r        <= `STM_RST_CNT;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_r && !aw_take;
      s_axi_wready  <= !w_have_r && !w_take;
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
        if (lane0) begin
          // Counter bytes are read-only and ignore writes
          if (aw_addr_r == `STM_ADDR_CTRL0) begin
            ctrl0_r <= w_data_r[7:0];
          end else if (aw_addr_r == `STM_ADDR_CTRL1) begin
            ctrl1_r <= w_data_r[7:0];
          end else if (aw_addr_r == `STM_ADDR_CMPA_LO) begin
            cmpa_r[7:0] <= w_data_r[7:0];
          end else if (aw_addr_r == `STM_ADDR_CMPA_HI) begin
            cmpa_r[CW-1:8] <= w_data_r[CW-9:0];
          end
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // AXI4-Lite read side
  // Read data is captured at the address handshake, so a counter
  // read returns the count of that cycle and stays stable after.
  reg [31:0] rd_mux;
  reg        rd_ok;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr == `STM_ADDR_CTRL0) begin
      rd_mux[7:0] = ctrl0_r;
    end else if (s_axi_araddr == `STM_ADDR_CTRL1) begin
      rd_mux[7:0] = ctrl1_r;
    end else if (s_axi_araddr == `STM_ADDR_CNT_LO) begin
      rd_mux[7:0] = cnt_r[7:0];
    end else if (s_axi_araddr == `STM_ADDR_CNT_HI) begin
      rd_mux[CW-9:0] = cnt_r[CW-1:8];
    end else if (s_axi_araddr == `STM_ADDR_CMPA_LO) begin
      rd_mux[7:0] = cmpa_r[7:0];
    end else if (s_axi_araddr == `STM_ADDR_CMPA_HI) begin
      rd_mux[CW-9:0] = cmpa_r[CW-1:8];
    end else if (s_axi_araddr == `STM_ADDR_FLAGS) begin
      rd_mux[`STM_FLAG_A] = match_a_flag_r;
      rd_mux[`STM_FLAG_P] = match_p_flag_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `STM_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: common/stm_consts.vh
// Constants for the standard timer with compare and PWM
`ifndef STM_CONSTS_VH
`define STM_CONSTS_VH
// Register byte addresses
`define STM_ADDR_CTRL0   8'h00
`define STM_ADDR_CTRL1   8'h04
`define STM_ADDR_CNT_LO  8'h08
`define STM_ADDR_CNT_HI  8'h0C
`define STM_ADDR_CMPA_LO 8'h10
`define STM_ADDR_CMPA_HI 8'h14
`define STM_ADDR_FLAGS   8'h18
// Control 0 fields
`define STM_C0_ON        3
`define STM_C0_RP_HI     2
// Control 1 fields
`define STM_C1_MODE_HI   7
`define STM_C1_MODE_LO   6
`define STM_C1_FUNC_HI   5
`define STM_C1_FUNC_LO   4
`define STM_C1_OC        3
`define STM_C1_POL       2
`define STM_C1_DPX       1
`define STM_C1_CCLR      0
// Flag register fields
`define STM_FLAG_A       0
`define STM_FLAG_P       1
// Modes
`define STM_MODE_CMP     2'b00
`define STM_MODE_CAP     2'b01
`define STM_MODE_PWM     2'b10
`define STM_MODE_TMR     2'b11
// Pin functions, compare mode
`define STM_CF_NONE      2'b00
`define STM_CF_LOW       2'b01
`define STM_CF_HIGH      2'b10
`define STM_CF_TOGGLE    2'b11
// Pin functions, PWM mode
`define STM_PF_INACT     2'b00
`define STM_PF_ACT       2'b01
`define STM_PF_PWM       2'b10
`define STM_PF_PULSE     2'b11
// Reset values
`define STM_RST_BYTE     8'h00
`define STM_RST_CNT      10'h000
// AXI responses
`define STM_RESP_OKAY    2'b00
`define STM_RESP_SLVERR  2'b10
`endif

// File: dv/stm_timer_props.sv
// Checker of bus handshakes and match flag behaviour
`default_nettype none
module stm_timer_chk (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        tick,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        match_a_flag_r,
  input wire logic        match_p_flag_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // Handshake steps
  sequence s_aw_take;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_w_take;
    s_axi_wvalid && s_axi_wready;
  endsequence
  wire w_take = s_axi_wvalid && s_axi_wready;
  ////////////////////////////////////////
  // Bus answers
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_wr_answer: assert property (s_aw_take ##0 s_w_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_wready_low: assert property (s_w_take |=> !s_axi_wready)
    else $error("wready high after take");
  // Flags set on timer ticks, flag A cleared only by writes
  chk_a_on_tick: assert property ($rose(match_a_flag_r) |-> $past(tick))
    else $error("flag A set without tick");
  chk_p_on_tick: assert property ($rose(match_p_flag_r) |-> $past(tick))
    else $error("flag P set without tick");
  chk_a_sticky: assert property ($fell(match_a_flag_r) |-> $past(w_take) || $past(w_take, 2) || $past(w_take, 3))
    else $error("flag A lost without write");
endmodule
`default_nettype wire

// File: dv/test_standard_timer_compare_pwm.sv
// Self-checking bench for the standard timer
`default_nettype none
`include "stm_consts.vh"
module test_standard_timer_compare_pwm;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, nrst, clk_en, tick, pin_out_r, pin_oe_r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, match_a_flag_r, match_p_flag_r;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          err_total, check_count, i;

  stm_timer dut (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .clk_en         (clk_en),
    .tick           (tick),
    .s_axi_awaddr   (s_axi_awaddr),
    .s_axi_awvalid  (s_axi_awvalid),
    .s_axi_awready  (s_axi_awready),
    .s_axi_wdata    (s_axi_wdata),
    .s_axi_wstrb    (s_axi_wstrb),
    .s_axi_wvalid   (s_axi_wvalid),
    .s_axi_wready   (s_axi_wready),
    .s_axi_bresp    (s_axi_bresp),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_rresp    (s_axi_rresp),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .pin_out_r      (pin_out_r),
    .pin_oe_r       (pin_oe_r),
    .match_a_flag_r (match_a_flag_r),
    .match_p_flag_r (match_p_flag_r)
  );

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  // Verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus write or read, bounded wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] rq, output logic [1:0] rr);
    logic ta, tw, tb, tar, trd;
    int n;
    @(posedge sys_clk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      if (!(s_axi_awvalid | s_axi_wvalid | s_axi_bready | s_axi_arvalid | s_axi_rready)) break;
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bready & s_axi_bvalid;
      tar = s_axi_arvalid & s_axi_arready;
      trd = s_axi_rready & s_axi_rvalid;
      rr = tb ? s_axi_bresp : s_axi_rresp;
      rq = s_axi_rdata;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      if (tar) s_axi_arvalid <= 1'b0;
      if (trd) s_axi_rready <= 1'b0;
    end
    if (n == 50) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, q, r);
    chk({30'h0, r}, {30'h0, `STM_RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00, q, r);
    chk(q, e);
  endtask
  // Flags P, A and pin level after settling
  task automatic st(input logic [2:0] e);
    repeat (2) @(negedge sys_clk);
    chk({29'h0, match_p_flag_r, match_a_flag_r, pin_out_r}, {29'h0, e});
  endtask
  // Timer tick pulses
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      tick <= 1'b1;
    end
    @(posedge sys_clk);
    tick <= 1'b0;
  endtask
  ////////////////////////////////////////
  // Reset values, byte packing, read-only counter, unmapped
  task automatic t_regs();
    rd(`STM_ADDR_CNT_LO, 32'h0);
    rd(`STM_ADDR_CNT_HI, 32'h0);
    rd(`STM_ADDR_CMPA_HI, 32'h0);
    wr(`STM_ADDR_CMPA_LO, 8'hA5);
    wr(`STM_ADDR_CMPA_HI, 8'hFF);
    rd(`STM_ADDR_CMPA_LO, 32'h0000_00A5);
    rd(`STM_ADDR_CMPA_HI, 32'h0000_0003);
    wr(`STM_ADDR_CNT_LO, 8'h55);
    rd(`STM_ADDR_CNT_LO, 32'h0);
    xfer(1'b0, 8'h40, 8'h00, q, r);
    chk({30'h0, r}, {30'h0, `STM_RESP_SLVERR});
    $display("t_regs done");
  endtask
  // Clear on A past a P match, toggle, stop and restart
  task automatic t_cmp();
    wr(`STM_ADDR_CMPA_HI, 8'h00);
    wr(`STM_ADDR_CMPA_LO, 8'hC8);
    wr(`STM_ADDR_CTRL1, 8'h31);
    wr(`STM_ADDR_CTRL0, 8'h09);
    st(3'b000);
    tk(200);
    rd(`STM_ADDR_CNT_LO, 32'h0000_00C8);
    st(3'b000);
    tk(1);
    rd(`STM_ADDR_CNT_LO, 32'h0);
    st(3'b011);
    tk(3);
    wr(`STM_ADDR_CTRL0, 8'h01);
    tk(2);
    rd(`STM_ADDR_CNT_LO, 32'h0000_0003);
    wr(`STM_ADDR_CTRL0, 8'h09);
    rd(`STM_ADDR_CNT_LO, 32'h0);
    st(3'b010);
    $display("t_cmp done");
  endtask
  // Clear on P match, both flags, pin moved by A only
  task automatic t_clr();
    wr(`STM_ADDR_CTRL0, 8'h01);
    wr(`STM_ADDR_CMPA_LO, 8'h05);
    wr(`STM_ADDR_CTRL1, 8'h30);
    wr(`STM_ADDR_FLAGS, 8'h03);
    wr(`STM_ADDR_CTRL0, 8'h09);
    st(3'b000);
    tk(6);
    st(3'b011);
    tk(122);
    rd(`STM_ADDR_CNT_LO, 32'h0000_0080);
    tk(1);
    rd(`STM_ADDR_CNT_LO, 32'h0);
    st(3'b111);
    $display("t_clr done");
  endtask
  // Forced PWM levels for each level and invert setting
  task automatic t_pwm();
    for (i = 0; i < 8; i++) begin
      wr(`STM_ADDR_CTRL0, 8'h00);
      wr(`STM_ADDR_CTRL1, {3'b100, i[2:0], 2'b00});
      wr(`STM_ADDR_CTRL0, 8'h08);
      st({2'b11, (i[2] ~^ i[1]) ^ i[0]});
      chk({31'h0, pin_oe_r}, 32'h1);
    end
    $display("t_pwm done");
  endtask
  // Timer mode: pin released, flags as compare, zero compare overflow
  task automatic t_tmr();
    wr(`STM_ADDR_CTRL0, 8'h00);
    wr(`STM_ADDR_FLAGS, 8'h03);
    wr(`STM_ADDR_CTRL1, 8'hC1);
    wr(`STM_ADDR_CTRL0, 8'h08);
    chk({31'h0, pin_oe_r}, 32'h0);
    tk(6);
    rd(`STM_ADDR_CNT_LO, 32'h0);
    chk({30'h0, match_p_flag_r, match_a_flag_r}, 32'h1);
    wr(`STM_ADDR_FLAGS, 8'h03);
    wr(`STM_ADDR_CMPA_LO, 8'h00);
    tk(1023);
    rd(`STM_ADDR_CNT_HI, 32'h0000_0003);
    tk(1);
    rd(`STM_ADDR_CNT_LO, 32'h0);
    chk({30'h0, match_p_flag_r, match_a_flag_r}, 32'h0);
    $display("t_tmr done");
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {nrst, tick, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'h1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_cmp();
    t_clr();
    t_pwm();
    t_tmr();
    conclude();
  end
endmodule
bind stm_timer stm_timer_chk u_chk (
  .sys_clk        (sys_clk),
  .nrst           (nrst),
  .tick           (tick),
  .s_axi_awvalid  (s_axi_awvalid),
  .s_axi_awready  (s_axi_awready),
  .s_axi_wvalid   (s_axi_wvalid),
  .s_axi_wready   (s_axi_wready),
  .s_axi_bvalid   (s_axi_bvalid),
  .s_axi_bready   (s_axi_bready),
  .s_axi_arvalid  (s_axi_arvalid),
  .s_axi_arready  (s_axi_arready),
  .s_axi_rvalid   (s_axi_rvalid),
  .s_axi_rready   (s_axi_rready),
  .s_axi_rdata    (s_axi_rdata),
  .match_a_flag_r (match_a_flag_r),
  .match_p_flag_r (match_p_flag_r)
);
`default_nettype wire
